//--- hdl/irq_regs.svh
/*
 * Register offsets, field positions, reset values and sizes of the
 * interrupt pending, active and priority block.
 * Assumes it is included by its bare name, before any use of its macros.
 */
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define IRQ_COUNT 33
`define IRQ_NUM_W 6
`define REG_ADDR_W 12
`define REG_DATA_W 32
`define PRIO_W 4
`define PRIO_REG_COUNT 9
`define PRIO_WORD_W 4

// ----------------------------------------------------------------------
// Byte offsets inside the controller window
// ----------------------------------------------------------------------
`define OFS_SET_ENABLE 12'h100
`define OFS_CLEAR_ENABLE 12'h180
`define OFS_SET_PENDING 12'h200
`define OFS_CLEAR_PENDING 12'h280
`define OFS_ACTIVE 12'h300
`define OFS_PRIORITY 12'h400
`define OFS_BIT_SPAN 12'h008
`define OFS_PRIO_SPAN 12'h024

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PRIO_LANE_W 8
`define PRIO_IMPL_LSB 4
`define FLAGS_RESET 1'b0
`define PRIO_RESET 4'h0
`define READ_ZERO 32'h0000_0000

`endif

//--- hdl/irq_pkg.sv
/*
 * Types shared by the interrupt state block and its helpers.
 * Assumes irq_regs.svh is on the include path.
 */
`include "irq_regs.svh"
`default_nettype none

package irq_pkg;

   // -------------------------------------------------------------------
   // Register access port
   // -------------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`REG_ADDR_W-1:0] addr;
      logic [3:0] byte_en;
      logic [`REG_DATA_W-1:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic rd_valid;
      logic [`REG_DATA_W-1:0] rd_data;
   } reg_rsp_t;

   // -------------------------------------------------------------------
   // Core exception events and chosen candidate
   // -------------------------------------------------------------------
   typedef struct packed {
      logic enter;
      logic leave;
      logic [`IRQ_NUM_W-1:0] num;
   } core_evt_t;

   typedef struct packed {
      logic valid;
      logic [`IRQ_NUM_W-1:0] num;
      logic [`PRIO_W-1:0] level;
   } cand_t;

   typedef enum {
      BANK_NONE,
      BANK_SET_EN,
      BANK_CLR_EN,
      BANK_SET_PEND,
      BANK_CLR_PEND,
      BANK_ACTIVE,
      BANK_PRIO
   } bank_sel_t;

endpackage

`default_nettype wire

//--- hdl/irq_edge_detect.sv
/*
 * Rising edge finder for the peripheral request lines.
 * Assumes the lines come from logic on the same clock.
 */
`include "irq_regs.svh"
`default_nettype none

module irq_edge_detect #(
   parameter int NUM_IRQ = `IRQ_COUNT
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [NUM_IRQ-1:0] lines_in,
   output logic [NUM_IRQ-1:0] rise_out
);
   typedef struct packed {
      logic [NUM_IRQ-1:0] prev;
   } edge_state_t;

   edge_state_t state_reg;
   edge_state_t state_next;

   // -------------------------------------------------------------------
   // Edge logic
   // -------------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      state_next.prev = lines_in;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign rise_out = lines_in & ~state_reg.prev;

endmodule

`default_nettype wire

//--- hdl/irq_priority_bank.sv
/*
 * Priority field storage, four byte lanes per word, upper nibble kept.
 * Assumes the caller decodes the word index and gives byte enables.
 */
`include "irq_regs.svh"
`default_nettype none

module irq_priority_bank #(
   parameter int NUM_IRQ = `IRQ_COUNT
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wr_in,
   input wire logic [`PRIO_WORD_W-1:0] word_in,
   input wire logic [3:0] byte_en_in,
   input wire logic [`REG_DATA_W-1:0] wdata_in,
   output logic [NUM_IRQ-1:0][`PRIO_W-1:0] prio_out,
   output logic [`REG_DATA_W-1:0] word_out
);
   typedef struct packed {
      logic [NUM_IRQ-1:0][`PRIO_W-1:0] prio;
   } prio_state_t;

   prio_state_t state_reg;
   prio_state_t state_next;

   // -------------------------------------------------------------------
   // Byte lane writes
   // -------------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      for (int i = 0; i < NUM_IRQ; i++)
      begin
         // RQ10 single lane update
         if (wr_in && (int'(word_in) == i / 4) && byte_en_in[i % 4])
         begin
            // RQ14 low nibble dropped
            state_next.prio[i] = wdata_in[(i % 4) * `PRIO_LANE_W
               + `PRIO_IMPL_LSB +: `PRIO_W];
         end
      end
   end

   // -------------------------------------------------------------------
   // Read word assembly
   // -------------------------------------------------------------------
   always_comb
   begin
      word_out = `READ_ZERO;
      for (int j = 0; j < 4; j++)
      begin
         // RQ11 lane j holds field 4m+j
         if (int'(word_in) * 4 + j < NUM_IRQ)
         begin
            word_out[j * `PRIO_LANE_W + `PRIO_IMPL_LSB +: `PRIO_W] =
               state_reg.prio[int'(word_in) * 4 + j];
         end
      end
   end

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         // RQ17 fields cleared
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign prio_out = state_reg.prio;

endmodule

`default_nettype wire

//--- hdl/irq_pending_active_priority.sv
/*
 * Per-interrupt enable, pending, active and priority state, with the
 * memory-mapped word and byte port and the best candidate for the core.
 * Assumes one access per cycle, aligned, and core enter/leave pulses.
 */
// Contract
// RQ1 - Clear-enable write of one disables; zero ignored; read shows enables.
// RQ2 - Set-pending write of one makes pending; zero ignored; read shows it.
// RQ3 - Set-pending one on an already pending interrupt changes nothing.
// RQ4 - Set-pending works on disabled interrupts; enable never gates pending.
// RQ5 - Clear-pending one removes pending; zero ignored; read shows pending.
// RQ6 - Clear-pending never touches the active flag.
// RQ7 - Active flag register is read-only, one bit per interrupt.
// RQ8 - Active bit reads one when active, also when active and pending.
// RQ9 - A 4-bit priority per interrupt held in nine words.
// RQ10 - Priority words take byte reads and writes without disturbing others.
// RQ11 - Word m lane zero holds interrupt 4m, lane three 4m+3.
// RQ12 - Priority fields cover interrupts zero through thirty-two.
// RQ13 - Set-enable one enables; disabled pending interrupt never offered.
// RQ14 - Only upper nibble of each priority byte kept; lower reads zero.
// RQ15 - Smaller priority value is more urgent; zero is highest.
// RQ16 - Pending on high line while not active, or on rising edge.
// RQ17 - Reset clears enable, pending, active and all priorities.
`include "irq_regs.svh"
`default_nettype none

module irq_pending_active_priority #(
   parameter int NUM_IRQ = `IRQ_COUNT
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire irq_pkg::reg_req_t reg_req_in,
   output irq_pkg::reg_rsp_t reg_rsp_out,
   input wire logic [NUM_IRQ-1:0] irq_lines_in,
   input wire irq_pkg::core_evt_t core_evt_in,
   output logic [NUM_IRQ-1:0] enabled_out,
   output logic [NUM_IRQ-1:0] pending_out,
   output logic [NUM_IRQ-1:0] active_out,
   output irq_pkg::cand_t cand_out
);
   import irq_pkg::*;

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [NUM_IRQ-1:0] enable;
      logic [NUM_IRQ-1:0] pending;
      logic [NUM_IRQ-1:0] active;
      reg_rsp_t rsp;
      cand_t cand;
   } ctl_state_t;

   ctl_state_t state_reg;
   ctl_state_t state_next;

   logic [NUM_IRQ-1:0] rise;
   logic [NUM_IRQ-1:0][`PRIO_W-1:0] prio;
   logic [`REG_DATA_W-1:0] prio_word;
   logic prio_wr;
   logic [`PRIO_WORD_W-1:0] prio_idx;
   bank_sel_t sel;
   logic word_hi;

   // -------------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------------
   function automatic logic [`REG_DATA_W-1:0] lane_mask(
      input logic [3:0] be
   );
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [`REG_DATA_W-1:0] bit_word(
      input logic [NUM_IRQ-1:0] v,
      input logic hi
   );
      logic [2*`REG_DATA_W-1:0] wide;
      wide = (2*`REG_DATA_W)'(v);
      return hi ? wide[2*`REG_DATA_W-1:`REG_DATA_W]
                : wide[`REG_DATA_W-1:0];
   endfunction

   function automatic logic [NUM_IRQ-1:0] bit_mask(
      input logic [`REG_DATA_W-1:0] d,
      input logic hi
   );
      logic [2*`REG_DATA_W-1:0] wide;
      wide = hi ? {d, `READ_ZERO} : {`READ_ZERO, d};
      return wide[NUM_IRQ-1:0];
   endfunction

   function automatic logic in_span(
      input logic [`REG_ADDR_W-1:0] a,
      input logic [`REG_ADDR_W-1:0] base,
      input logic [`REG_ADDR_W-1:0] span
   );
      return (a >= base) && (a < base + span);
   endfunction

   // RQ15 lower value wins
   function automatic cand_t pick_best(
      input logic [NUM_IRQ-1:0] ready,
      input logic [NUM_IRQ-1:0][`PRIO_W-1:0] lv
   );
      cand_t best;
      best = '0;
      for (int i = 0; i < NUM_IRQ; i++)
      begin
         if (ready[i] && (!best.valid || lv[i] < best.level))
         begin
            best.valid = 1'b1;
            best.num = `IRQ_NUM_W'(i);
            best.level = lv[i];
         end
      end
      return best;
   endfunction

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   always_comb
   begin
      if (in_span(reg_req_in.addr, `OFS_SET_ENABLE, `OFS_BIT_SPAN))
      begin
         sel = BANK_SET_EN;
      end
      else if (in_span(reg_req_in.addr, `OFS_CLEAR_ENABLE, `OFS_BIT_SPAN))
      begin
         sel = BANK_CLR_EN;
      end
      else if (in_span(reg_req_in.addr, `OFS_SET_PENDING, `OFS_BIT_SPAN))
      begin
         sel = BANK_SET_PEND;
      end
      else if (in_span(reg_req_in.addr, `OFS_CLEAR_PENDING, `OFS_BIT_SPAN))
      begin
         sel = BANK_CLR_PEND;
      end
      else if (in_span(reg_req_in.addr, `OFS_ACTIVE, `OFS_BIT_SPAN))
      begin
         sel = BANK_ACTIVE;
      end
      else if (in_span(reg_req_in.addr, `OFS_PRIORITY, `OFS_PRIO_SPAN))
      begin
         sel = BANK_PRIO;
      end
      else
      begin
         sel = BANK_NONE;
      end
   end

   assign word_hi = reg_req_in.addr[2];
   assign prio_idx = reg_req_in.addr[`PRIO_WORD_W+1:2];
   assign prio_wr = reg_req_in.wr && (sel == BANK_PRIO);

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   irq_edge_detect #(
      .NUM_IRQ(NUM_IRQ)
   ) u_edge (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .lines_in(irq_lines_in),
      .rise_out(rise)
   );

   // RQ9 priority storage bank
   // RQ12 all fields covered
   irq_priority_bank #(
      .NUM_IRQ(NUM_IRQ)
   ) u_prio (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_in(prio_wr),
      .word_in(prio_idx),
      .byte_en_in(reg_req_in.byte_en),
      .wdata_in(reg_req_in.wdata),
      .prio_out(prio),
      .word_out(prio_word)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb
   begin
      logic [`REG_DATA_W-1:0] wd;
      logic [NUM_IRQ-1:0] wmask;
      logic [NUM_IRQ-1:0] sw_set_en;
      logic [NUM_IRQ-1:0] sw_clr_en;
      logic [NUM_IRQ-1:0] sw_set_pend;
      logic [NUM_IRQ-1:0] sw_clr_pend;
      logic [NUM_IRQ-1:0] enter_mask;
      logic [NUM_IRQ-1:0] leave_mask;
      logic [NUM_IRQ-1:0] hw_set;
      logic [NUM_IRQ-1:0] ready;

      hw_set = '0;
      ready = '0;
      wd = reg_req_in.wdata & lane_mask(reg_req_in.byte_en);
      wmask = bit_mask(wd, word_hi);
      sw_set_en = '0;
      sw_clr_en = '0;
      sw_set_pend = '0;
      sw_clr_pend = '0;
      enter_mask = '0;
      leave_mask = '0;
      state_next = state_reg;

      if (reg_req_in.wr)
      begin
         case (sel)
            BANK_SET_EN:
            begin
               // RQ13 set-enable ones
               sw_set_en = wmask;
            end
            BANK_CLR_EN:
            begin
               // RQ1 clear-enable ones
               sw_clr_en = wmask;
            end
            BANK_SET_PEND:
            begin
               // RQ2 set-pending ones
               sw_set_pend = wmask;
            end
            BANK_CLR_PEND:
            begin
               // RQ5 clear-pending ones
               sw_clr_pend = wmask;
            end
            default:
            begin
               // RQ7 active word ignores writes
               sw_set_en = '0;
            end
         endcase
      end

      if (int'(core_evt_in.num) < NUM_IRQ)
      begin
         enter_mask[core_evt_in.num] = core_evt_in.enter;
         leave_mask[core_evt_in.num] = core_evt_in.leave;
      end

      state_next.enable = (state_reg.enable | sw_set_en) & ~sw_clr_en;

      // RQ16 level while idle or edge
      hw_set = rise | (irq_lines_in & ~state_reg.active & ~enter_mask);
      // RQ4 no enable term here
      // RQ3 OR keeps pending as is
      state_next.pending = hw_set | sw_set_pend
         | (state_reg.pending & ~sw_clr_pend & ~enter_mask);

      // RQ6 active untouched by clear
      // RQ8 active kept while pending again
      state_next.active = enter_mask
         | (state_reg.active & ~leave_mask);

      // RQ13 only enabled ones offered
      ready = state_next.pending & state_next.enable & ~state_next.active;
      state_next.cand = pick_best(ready, prio);

      state_next.rsp.rd_valid = reg_req_in.rd;
      state_next.rsp.rd_data = `READ_ZERO;
      if (reg_req_in.rd)
      begin
         case (sel)
            BANK_SET_EN, BANK_CLR_EN:
            begin
               // RQ1 read shows enables
               state_next.rsp.rd_data = bit_word(state_reg.enable, word_hi);
            end
            BANK_SET_PEND, BANK_CLR_PEND:
            begin
               // RQ5 read shows pending
               state_next.rsp.rd_data = bit_word(state_reg.pending, word_hi);
            end
            BANK_ACTIVE:
            begin
               // RQ7 active flags read
               state_next.rsp.rd_data = bit_word(state_reg.active, word_hi);
            end
            BANK_PRIO:
            begin
               // RQ11 lane layout
               state_next.rsp.rd_data = prio_word;
            end
            default:
            begin
               state_next.rsp.rd_data = `READ_ZERO;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         // RQ17 flags cleared
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign reg_rsp_out = state_reg.rsp;
   assign enabled_out = state_reg.enable;
   assign pending_out = state_reg.pending;
   assign active_out = state_reg.active;
   assign cand_out = state_reg.cand;

endmodule

`default_nettype wire

//--- verification/irq_state_checker.sv
/*
 * Assertion checker for the interrupt pending, active and priority block.
 * Assumes it is bound to the block's top module by the bind below.
 */
`include "irq_regs.svh"
`default_nettype none

module irq_state_checker
   import irq_pkg::*;
#(
   parameter int NUM_IRQ = `IRQ_COUNT
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire irq_pkg::reg_req_t reg_req_in,
   input wire irq_pkg::reg_rsp_t reg_rsp_out,
   input wire logic [NUM_IRQ-1:0] irq_lines_in,
   input wire irq_pkg::core_evt_t core_evt_in,
   input wire logic [NUM_IRQ-1:0] enabled_out,
   input wire logic [NUM_IRQ-1:0] pending_out,
   input wire logic [NUM_IRQ-1:0] active_out,
   input wire irq_pkg::cand_t cand_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_wr_bit0(ofs);
      reg_req_in.wr && reg_req_in.addr == ofs && reg_req_in.byte_en[0]
         && reg_req_in.wdata[0] && !core_evt_in.enter;
   endsequence
   sequence s_lone_rd;
      reg_req_in.rd ##1 !reg_req_in.rd;
   endsequence

   a_clear_en_bit: assert property (
      s_wr_bit0(`OFS_CLEAR_ENABLE) |=> !enabled_out[0])
      else $error("clear-enable write left irq 0 enabled");
   a_set_pend_bit: assert property (
      s_wr_bit0(`OFS_SET_PENDING) |=> pending_out[0])
      else $error("set-pending write did not pend irq 0");
   a_rd_one_pulse: assert property (
      s_lone_rd |-> reg_rsp_out.rd_valid ##1 !reg_rsp_out.rd_valid)
      else $error("read answer not a single pulse");
   a_rd_idle_zero: assert property (
      !reg_rsp_out.rd_valid |-> reg_rsp_out.rd_data == `READ_ZERO)
      else $error("read data not zero while idle");
   a_clr_pend_act: assert property (
      reg_req_in.wr && reg_req_in.addr == `OFS_CLEAR_PENDING
      && !core_evt_in.enter && !core_evt_in.leave |=> $stable(active_out))
      else $error("clear-pending changed active flags");
   a_cand_legal: assert property (
      cand_out.valid |-> enabled_out[cand_out.num]
      && pending_out[cand_out.num] && !active_out[cand_out.num])
      else $error("candidate not enabled, pending and inactive");
   a_line_pends: assert property (
      !core_evt_in.enter |=> (pending_out & $past(irq_lines_in)
      & ~$past(active_out)) == ($past(irq_lines_in) & ~$past(active_out)))
      else $error("high idle line did not pend");
   a_enter_active: assert property (
      core_evt_in.enter && core_evt_in.num < NUM_IRQ
      |=> active_out[$past(core_evt_in.num)])
      else $error("entry did not set the active flag");
   a_leave_clear: assert property (
      core_evt_in.leave && !core_evt_in.enter && core_evt_in.num < NUM_IRQ
      |=> !active_out[$past(core_evt_in.num)])
      else $error("return did not clear the active flag");
endmodule

bind irq_pending_active_priority irq_state_checker #(.NUM_IRQ(NUM_IRQ))
   u_chk (.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
   .reg_rsp_out(reg_rsp_out), .irq_lines_in(irq_lines_in),
   .core_evt_in(core_evt_in), .enabled_out(enabled_out),
   .pending_out(pending_out), .active_out(active_out),
   .cand_out(cand_out));

`default_nettype wire

//--- verification/irq_partner.sv
/*
 * Model of the request lines and the core's entry and return.
 * Assumes the bench gives levels, take and done at the falling edge.
 */
`include "irq_regs.svh"
`default_nettype none

module irq_partner
   import irq_pkg::*;
#(
   parameter int NUM_IRQ = `IRQ_COUNT
) (
   input wire logic clk_in,
   input wire logic [NUM_IRQ-1:0] level_in,
   input wire logic take_in,
   input wire logic done_in,
   input wire irq_pkg::cand_t cand_in,
   output logic [NUM_IRQ-1:0] lines_out,
   output irq_pkg::core_evt_t evt_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy_reg;
   logic [`IRQ_NUM_W-1:0] cur_reg;

   // ----------------------------------------------------------------
   // Lines and core events, one pulse per entry or return
   // ----------------------------------------------------------------
   initial
   begin
      lines_out = '0;
      evt_out = '0;
      busy_reg = 1'b0;
      cur_reg = '0;
   end
   always @(negedge clk_in)
   begin
      lines_out <= level_in;
      evt_out <= '0;
      if (take_in && !busy_reg && cand_in.valid)
      begin
         evt_out <= '{enter: 1'b1, leave: 1'b0, num: cand_in.num};
         cur_reg <= cand_in.num;
         busy_reg <= 1'b1;
      end
      else if (done_in && busy_reg)
      begin
         evt_out <= '{enter: 1'b0, leave: 1'b1, num: cur_reg};
         busy_reg <= 1'b0;
      end
   end
endmodule

`default_nettype wire

//--- verification/tb_irq_pending_active_priority.sv
/*
 * Self-checking bench for the interrupt state block.
 * Assumes the design files, checker and partner are compiled before.
 */
`include "irq_regs.svh"
`default_nettype none

module tb_irq_pending_active_priority
   import irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   reg_req_t req = '0;
   reg_rsp_t rsp;
   core_evt_t evt;
   cand_t cand;
   logic [32:0] lvl = '0;
   logic [32:0] lines, en, pend, act;
   logic take = 1'b0;
   logic done = 1'b0;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;

   irq_pending_active_priority u_dut (.clk_in(clk_in), .rst_in(rst_in),
      .reg_req_in(req), .reg_rsp_out(rsp), .irq_lines_in(lines),
      .core_evt_in(evt), .enabled_out(en), .pending_out(pend),
      .active_out(act), .cand_out(cand));
   irq_partner u_far (.clk_in(clk_in), .level_in(lvl), .take_in(take),
      .done_in(done), .cand_in(cand), .lines_out(lines), .evt_out(evt));

   // ----------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial
   begin
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a,
      input logic [3:0] be, input logic [31:0] d);
      @(negedge clk_in);
      req <= '{wr: w, rd: !w, addr: a, byte_en: be, wdata: d};
      @(negedge clk_in);
      req <= '0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      acc(1'b1, a, 4'hF, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, a, 4'hF, 32'h0000_0000);
      chk({rsp.rd_valid, rsp.rd_data}, {1'b1, exp});
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk(en | pend | act, 33'h0_0000_0000);
      rd(`OFS_PRIORITY + 12'h020, 32'h0000_0000);
      $display("reset test done");
   endtask
   task automatic t_enable();
      wr(`OFS_SET_ENABLE, 32'hFFFF_FFFF);
      wr(`OFS_SET_ENABLE + 12'h004, 32'h0000_0001);
      chk(en, 33'h1_FFFF_FFFF);
      wr(`OFS_CLEAR_ENABLE, 32'h0000_00F1);
      wr(`OFS_CLEAR_ENABLE, 32'h0000_0000);
      chk(en, 33'h1_FFFF_FF0E);
      rd(`OFS_CLEAR_ENABLE, 32'hFFFF_FF0E);
      $display("enable test done");
   endtask
   task automatic t_pend();
      wr(`OFS_SET_PENDING, 32'h0000_0010);
      chk(pend, 33'h0_0000_0010);
      chk(33'(cand.valid), 33'h0_0000_0000);
      wr(`OFS_SET_PENDING, 32'h0000_0010);
      chk(pend, 33'h0_0000_0010);
      wr(`OFS_SET_PENDING + 12'h004, 32'h0000_0001);
      wr(`OFS_SET_PENDING, 32'h0000_0000);
      rd(`OFS_SET_PENDING, 32'h0000_0010);
      chk(pend, 33'h1_0000_0010);
      wr(`OFS_CLEAR_PENDING + 12'h004, 32'h0000_0001);
      wr(`OFS_CLEAR_PENDING, 32'h0000_0000);
      chk(pend, 33'h0_0000_0010);
      wr(`OFS_CLEAR_PENDING, 32'h0000_0010);
      rd(`OFS_CLEAR_PENDING, 32'h0000_0000);
      $display("pending test done");
   endtask
   task automatic t_active();
      @(negedge clk_in);
      lvl <= 33'h0_0000_0200;
      repeat (3) @(negedge clk_in);
      chk(pend, 33'h0_0000_0200);
      take <= 1'b1;
      repeat (4) @(negedge clk_in);
      take <= 1'b0;
      chk(act | pend, 33'h0_0000_0200);
      wr(`OFS_SET_PENDING, 32'h0000_0200);
      rd(`OFS_ACTIVE, 32'h0000_0200);
      wr(`OFS_ACTIVE, 32'h0000_0000);
      chk(act, 33'h0_0000_0200);
      wr(`OFS_CLEAR_PENDING, 32'h0000_0200);
      chk({pend[9], act[9]}, 33'h0_0000_0001);
      done <= 1'b1;
      repeat (2) @(negedge clk_in);
      done <= 1'b0;
      repeat (4) @(negedge clk_in);
      chk({pend[9], act[9]}, 33'h0_0000_0002);
      lvl <= '0;
      wr(`OFS_CLEAR_PENDING, 32'h0000_0200);
      chk(pend, 33'h0_0000_0000);
      $display("active test done");
   endtask
   task automatic t_prio();
      for (int m = 0; m < 8; m++)
         wr(`OFS_PRIORITY + 12'(4 * m), {4{4'(m + 1), 4'hF}});
      acc(1'b1, `OFS_PRIORITY + 12'h00C, 4'h4, 32'hFFFF_FFFF);
      acc(1'b1, `OFS_PRIORITY + 12'h020, 4'h1, 32'hFFFF_FFAB);
      for (int m = 0; m < 8; m++)
         if (m != 3)
            rd(`OFS_PRIORITY + 12'(4 * m), {4{4'(m + 1), 4'h0}});
      rd(`OFS_PRIORITY + 12'h00C, 32'h40F0_4040);
      rd(`OFS_PRIORITY + 12'h020, 32'h0000_00A0);
      $display("priority test done");
   endtask
   task automatic t_order();
      wr(`OFS_PRIORITY, 32'h2020_3030);
      wr(`OFS_SET_PENDING, 32'h0000_000F);
      chk(33'(cand), 33'h0_0000_0422);
      wr(`OFS_CLEAR_PENDING, 32'h0000_000F);
      chk(33'(cand.valid), 33'h0_0000_0000);
      $display("order test done");
   endtask

   initial
   begin
      repeat (6) @(negedge clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_enable();
      t_pend();
      t_active();
      t_prio();
      t_order();
      stop_test();
   end
endmodule

`default_nettype wire
